// ==== src/msmp_top.sv ====
// Purpose: media interface mode select, reference clock and phy poll
// Assumes: register port sits behind the serial control front end
// Notes: mode changes take effect at reset release or soft reset
//
// Summary of operation
// - strap high at start, or override with type bit 1, selects MII.
// - strap low at start, or override with type bit 0, selects RMII.
// - phy/soc strap low, or override with attachment 00, selects PHY mode.
// - phy/soc strap high, or override with attachment 01, selects SOC mode.
// - clock-source bit 1, the default, takes the RMII reference from PHY.
// - clock-source bit 0 in RMII makes and drives the 50MHz reference out.
// - PHY mode polls the PHY link status by management read frames.
// - PHY address is phy_address_high_bits bits 6:4 above the two address pins.
// - no carrier sense or collision inputs are used.
// - SOC mode with MII carries traffic on the port-B pin set.
// - no reset is driven to the external PHY.
// - without override, straps are latched at reset release.
// - PHY/SOC strap low: media clocks input; high: driven out.
// - register settings replace pin values only while override is 1.
// - a new register mode applies only after writing 1 to soft reset.
`timescale 1ns/1ns
`include "msmp_map.svh"
module msmp_top #(
   parameter int POLL_CYCLES = `POLL_CYC,
   parameter int MDC_HALF = `MDC_HALF_CYC
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   input wire logic linkIndIn,
   output logic linkIndOut,
   output logic linkIndOe,
   input wire logic phySocStrap,
   input wire logic [1:0] addrSel,
   input wire logic refClkIn,
   output logic refClkOut,
   output logic refClkOe,
   output logic mdc,
   output logic mdcOe,
   input wire logic mdioIn,
   output logic mdioOut,
   output logic mdioOe,
   output msmp_pkg::msmp_media_t media,
   output msmp_pkg::msmp_mode_t modeStatus
);
   import msmp_pkg::*;

   typedef struct packed {
      logic taken;
      logic strapMii;
      logic strapSoc;
      logic [7:0] cfg;
      logic [7:0] phyHi;
      msmp_mode_t act;
      msmp_media_t med;
      msmp_poll_t st;
      logic [31:0] pollCnt;
      logic start;
      logic linkUp;
      logic statValid;
      logic [2:0] refDiv;
      logic refOut;
      logic refPrev;
      logic [7:0] refAge;
      logic ledOe;
      logic linkOutN;
      logic mdioEn;
      logic [7:0] rdData;
   } msmp_state_t;

   msmp_state_t s_r;
   msmp_state_t s_nxt;

   logic [5:0] pinsSync;
   logic strapMiiSync;
   logic strapSocSync;
   logic [1:0] addrSync;
   logic refSync;
   logic mdioSync;
   logic rdDone;
   logic [15:0] rdWord;
   logic [4:0] phyAddr;
   logic phyMdc;
   logic phyMdioOut;
   logic phyMdioOe;

   // every pin from outside mclk passes two flops
   msmp_sync #(
      .W(6)
   ) u_sync (
      .mclk(mclk),
      .din({linkIndIn, phySocStrap, addrSel, refClkIn, mdioIn}),
      .dout(pinsSync)
   );

   assign strapMiiSync = pinsSync[5];
   assign strapSocSync = pinsSync[4];
   assign addrSync = pinsSync[3:2];
   assign refSync = pinsSync[1];
   assign mdioSync = pinsSync[0];

   assign phyAddr = {s_r.phyHi[`PHYHI_MSB:`PHYHI_LSB], addrSync};

   msmp_mdio_rd #(
      .HALF(MDC_HALF)
   ) u_mdio (
      .mclk(mclk),
      .reset(reset),
      .start(s_r.start),
      .phyAddr(phyAddr),
      .regNum(`PHY_STAT_REG),
      .mdioIn(mdioSync),
      .mdc(phyMdc),
      .mdioOut(phyMdioOut),
      .mdioOe(phyMdioOe),
      .done(rdDone),
      .rdData(rdWord)
   );

   // pick pin or register source for each mode field
   function automatic msmp_mode_t resolve(
      input logic [7:0] cfg,
      input logic strapMii,
      input logic strapSoc
   );
      msmp_mode_t m;
      if (cfg[`CFG_OVERRIDE]) begin
         m.miiSel = cfg[`CFG_MII_SEL];
         m.attach = cfg[`CFG_ATTACH_HI:`CFG_ATTACH_LO];
      end else begin
         m.miiSel = strapMii;
         m.attach = strapSoc ? `ATTACH_SOC : `ATTACH_PHY;
      end
      m.clkInt = !cfg[`CFG_CLK_SRC];
      return m;
   endfunction : resolve

   // steering of pins from the active mode
   function automatic msmp_media_t steer(input msmp_mode_t m);
      msmp_media_t d;
      logic soc;
      logic phy;
      soc = m.attach == `ATTACH_SOC;
      phy = m.attach == `ATTACH_PHY;
      d.portBEn = soc && m.miiSel;
      d.portAEn = !(soc && m.miiSel);
      d.mediaClkOe = soc;
      d.rmii = !m.miiSel;
      d.mdcOe = phy;
      d.refOe = m.clkInt && !m.miiSel;
      return d;
   endfunction : steer

   logic softReset;
   logic phyMode;

   always_comb begin
      s_nxt = s_r;
      s_nxt.start = 1'b0;
      softReset = regWrite && (regAddr == `REG_SOFT_RESET) &&
                  regWrData[`SOFT_RESET_BIT];
      phyMode = s_r.act.attach == `ATTACH_PHY;

      // mode config writes only stage the new settings, phy address high bits apply at once
      if (regWrite) begin
         case (regAddr)
            `REG_MODE_CFG: begin
               s_nxt.cfg = regWrData;
            end
            `REG_PHY_ADDR_HI: begin
               s_nxt.phyHi = regWrData;
            end
            default: begin
               s_nxt.cfg = s_r.cfg;
            end
         endcase
      end

      // register reads, unmapped reads return zero
      if (regRead) begin
         case (regAddr)
            `REG_MODE_CFG: begin
               s_nxt.rdData = s_r.cfg;
            end
            `REG_PHY_ADDR_HI: begin
               s_nxt.rdData = s_r.phyHi;
            end
            `REG_STATUS: begin
               s_nxt.rdData = {1'b0, s_r.refAge < `REF_TIMEOUT,
                               s_r.statValid, s_r.linkUp, s_r.act.clkInt,
                               s_r.act.attach, s_r.act.miiSel};
            end
            default: begin
               s_nxt.rdData = 8'h00;
            end
         endcase
      end

      // straps latched once, first cycle after reset release
      if (!s_r.taken) begin
         s_nxt.taken = 1'b1;
         s_nxt.strapMii = strapMiiSync;
         s_nxt.strapSoc = strapSocSync;
         s_nxt.act = resolve(s_r.cfg, strapMiiSync, strapSocSync);
      end else if (softReset) begin
         // new mode only takes hold here
         s_nxt.act = resolve(s_r.cfg, s_r.strapMii, s_r.strapSoc);
         s_nxt.st = PS_COUNT;
         s_nxt.pollCnt = 32'(POLL_CYCLES - 1);
         s_nxt.linkUp = 1'b0;
         s_nxt.statValid = 1'b0;
      end
      s_nxt.med = steer(s_nxt.act);
      // led pin becomes an output once the strap has been sampled
      s_nxt.ledOe = s_nxt.taken;

      // periodic link status poll
      case (s_r.st)
         PS_COUNT: begin
            if (!phyMode || softReset) begin
               s_nxt.pollCnt = 32'(POLL_CYCLES - 1);
            end else if (s_r.pollCnt == 32'h0000_0000) begin
               s_nxt.start = 1'b1;
               s_nxt.st = PS_READ;
            end else begin
               s_nxt.pollCnt = s_r.pollCnt - 32'h0000_0001;
            end
         end
         PS_READ: begin
            if (rdDone) begin
               s_nxt.st = PS_COUNT;
               s_nxt.pollCnt = 32'(POLL_CYCLES - 1);
               if (phyMode) begin
                  s_nxt.linkUp = rdWord[`PHY_LINK_BIT];
                  s_nxt.statValid = 1'b1;
               end
            end
         end
         default: begin
            s_nxt.st = PS_COUNT;
         end
      endcase
      if (!phyMode) begin
         s_nxt.linkUp = 1'b0;
         s_nxt.statValid = 1'b0;
      end

      // internal 50MHz reference, divide by five
      if (s_r.act.clkInt && !s_r.act.miiSel) begin
         if (s_r.refDiv == 3'(`REF_DIV - 1)) begin
            s_nxt.refDiv = 3'h0;
         end else begin
            s_nxt.refDiv = s_r.refDiv + 3'h1;
         end
         s_nxt.refOut = s_nxt.refDiv < `REF_HIGH_CNT;
      end else begin
         // park on the last count so the first pulse is full width
         s_nxt.refDiv = 3'(`REF_DIV - 1);
         s_nxt.refOut = 1'b0;
      end

      // external reference liveness from sampled edges
      s_nxt.refPrev = refSync;
      if (refSync != s_r.refPrev) begin
         s_nxt.refAge = 8'h00;
      end else if (s_r.refAge != `REF_AGE_MAX) begin
         s_nxt.refAge = s_r.refAge + 8'h01;
      end

      // pin controls registered from their final next values
      s_nxt.linkOutN = !s_nxt.linkUp;
      s_nxt.mdioEn = phyMdioOe && s_nxt.med.mdcOe;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         s_r <= '0;
         s_r.cfg <= `CFG_RST;
         s_r.phyHi <= `PHYHI_RST;
         s_r.st <= PS_COUNT;
         s_r.pollCnt <= 32'(POLL_CYCLES - 1);
         s_r.refAge <= `REF_AGE_MAX;
         s_r.linkOutN <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // media pins take no carrier sense or collision, no phy reset
   assign media = s_r.med;
   assign modeStatus = s_r.act;
   assign regRdData = s_r.rdData;
   assign linkIndOut = s_r.linkOutN;
   assign linkIndOe = s_r.ledOe;
   assign refClkOut = s_r.refOut;
   assign refClkOe = s_r.med.refOe;
   assign mdc = phyMdc;
   assign mdcOe = s_r.med.mdcOe;
   assign mdioOut = phyMdioOut;
   assign mdioOe = s_r.mdioEn;
endmodule : msmp_top

// ==== common/msmp_map.svh ====
// Purpose: register offsets, field positions, reset values and timing
// Assumes: 250 MHz mclk
// Notes: included by every design file that needs the numbers
`ifndef MSMP_MAP_SVH
`define MSMP_MAP_SVH

// register offsets
`define REG_SOFT_RESET 8'h00
`define REG_MODE_CFG 8'h01
`define REG_PHY_ADDR_HI 8'h1e
`define REG_STATUS 8'h50

// interface_mode_config fields
`define CFG_OVERRIDE 0
`define CFG_ATTACH_HI 4
`define CFG_ATTACH_LO 3
`define CFG_MII_SEL 5
`define CFG_CLK_SRC 6
`define CFG_RST 8'h40

// phy_address_high_bits fields
`define PHYHI_MSB 6
`define PHYHI_LSB 4
`define PHYHI_RST 8'h00

// soft reset bit
`define SOFT_RESET_BIT 0

// attachment encodings
`define ATTACH_PHY 2'b00
`define ATTACH_SOC 2'b01

// clock and timing
`define CLK_MHZ 250
`define MDC_HALF_NS 200
`define MDC_HALF_CYC ((`MDC_HALF_NS * `CLK_MHZ) / 1000)
`define POLL_US 1000
`define POLL_CYC (`POLL_US * `CLK_MHZ)
`define REF_MHZ 50
`define REF_DIV (`CLK_MHZ / `REF_MHZ)
`define REF_HIGH_CNT 3'd2
`define REF_TIMEOUT 8'd64
`define REF_AGE_MAX 8'hff

// management frame layout
`define MDIO_HDR_BITS 46
`define MDIO_PREAMBLE 32'hffffffff
`define MDIO_START 2'b01
`define MDIO_OP_READ 2'b10
`define MDIO_TA_FIRST 7'd46
`define MDIO_DATA_FIRST 7'd48
`define MDIO_LAST_BIT 7'd63
`define PHY_STAT_REG 5'h01
`define PHY_LINK_BIT 2

`endif

// ==== common/msmp_pkg.sv ====
// Purpose: types shared by the mode select and phy poll block
// Assumes: numbers live in msmp_map.svh
// Notes: none
package msmp_pkg;

   typedef struct packed {
      logic miiSel;
      logic [1:0] attach;
      logic clkInt;
   } msmp_mode_t;

   typedef struct packed {
      logic portAEn;
      logic portBEn;
      logic mediaClkOe;
      logic rmii;
      logic mdcOe;
      logic refOe;
   } msmp_media_t;

   typedef enum logic [1:0] {
      PS_COUNT = 2'b01,
      PS_READ = 2'b10
   } msmp_poll_t;

endpackage : msmp_pkg

// ==== src/msmp_sync.sv ====
// Purpose: two flip-flop synchroniser for pins from outside mclk
// Assumes: inputs are slow levels or sampled clocks
// Notes: stages carry no reset, settle while reset is held
`timescale 1ns/1ns
module msmp_sync #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } msmp_sync_t;

   msmp_sync_t s_r;
   msmp_sync_t s_nxt;

   always_comb begin
      s_nxt.meta = din;
      s_nxt.stable = s_r.meta;
   end

   always_ff @(posedge mclk) begin
      s_r <= s_nxt;
   end

   assign dout = s_r.stable;
endmodule : msmp_sync

// ==== src/msmp_mdio_rd.sv ====
// Purpose: one management read frame over mdc/mdio
// Assumes: mdioIn already synchronised
// Notes: drives on mdc fall, samples on mdc rise
`timescale 1ns/1ns
`include "msmp_map.svh"
module msmp_mdio_rd #(
   parameter int HALF = `MDC_HALF_CYC
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic start,
   input wire logic [4:0] phyAddr,
   input wire logic [4:0] regNum,
   input wire logic mdioIn,
   output logic mdc,
   output logic mdioOut,
   output logic mdioOe,
   output logic done,
   output logic [15:0] rdData
);
   import msmp_pkg::*;

   typedef struct packed {
      logic busy;
      logic mdc;
      logic out;
      logic oe;
      logic done;
      logic [7:0] div;
      logic [6:0] bitCnt;
      logic [`MDIO_HDR_BITS-1:0] hdr;
      logic [15:0] data;
   } msmp_mdio_t;

   msmp_mdio_t s_r;
   msmp_mdio_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (!s_r.busy) begin
         s_nxt.mdc = 1'b0;
         s_nxt.oe = 1'b0;
         s_nxt.out = 1'b1;
         if (start) begin
            s_nxt.busy = 1'b1;
            s_nxt.hdr = {`MDIO_PREAMBLE, `MDIO_START, `MDIO_OP_READ,
                         phyAddr, regNum};
            s_nxt.bitCnt = 7'h00;
            s_nxt.div = 8'h00;
            s_nxt.oe = 1'b1;
         end
      end else if (s_r.div == 8'(HALF - 1)) begin
         s_nxt.div = 8'h00;
         s_nxt.mdc = !s_r.mdc;
         if (!s_r.mdc) begin
            // rising edge: capture read data
            if (s_r.bitCnt >= `MDIO_DATA_FIRST) begin
               s_nxt.data = {s_r.data[14:0], mdioIn};
            end
         end else if (s_r.bitCnt == `MDIO_LAST_BIT) begin
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
            s_nxt.oe = 1'b0;
            s_nxt.mdc = 1'b0;
         end else begin
            s_nxt.bitCnt = s_r.bitCnt + 7'h01;
            s_nxt.hdr = {s_r.hdr[`MDIO_HDR_BITS-2:0], 1'b1};
            s_nxt.out = s_r.hdr[`MDIO_HDR_BITS-2];
            // release the line from turnaround on
            s_nxt.oe = s_nxt.bitCnt < `MDIO_TA_FIRST;
         end
      end else begin
         s_nxt.div = s_r.div + 8'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign mdc = s_r.mdc;
   assign mdioOut = s_r.out;
   assign mdioOe = s_r.oe;
   assign done = s_r.done;
   assign rdData = s_r.data;
endmodule : msmp_mdio_rd

// ==== testbench/msmp_top_asserts.sv ====
// Purpose: port checks for mode select, ref clock and phy poll
// Assumes: one mclk domain, sync reset
// Notes: bound into msmp_top at the foot of this file
`timescale 1ns/1ns
`include "msmp_map.svh"
module msmp_top_asserts #(
   parameter int MDC_HALF = 4
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic linkIndIn,
   input wire logic phySocStrap,
   input wire logic refClkOut,
   input wire logic refClkOe,
   input wire logic mdc,
   input wire logic mdcOe,
   input wire logic mdioOut,
   input wire logic mdioOe,
   input wire msmp_pkg::msmp_media_t media,
   input wire msmp_pkg::msmp_mode_t modeStatus
);
   import msmp_pkg::*;
   // host drives the 46 header bits, two half periods each
   localparam int HDR_LEN = 2 * MDC_HALF * `MDIO_HDR_BITS;
   logic [7:0] cfgShadow_r;
   logic [1:0] rstHist_r;
   logic [15:0] oeLen_r;
   logic cutFrame_r;
   wire softRst = regWrite && regAddr == `REG_SOFT_RESET && regWrData[0];
   // outputs settle two edges after release
   wire settled = rstHist_r == 2'b00;
   always_ff @(posedge mclk) begin
      rstHist_r <= {rstHist_r[0], reset};
      oeLen_r <= mdioOe ? oeLen_r + 16'h0001 : 16'h0000;
      // frames cut by reset or soft reset are excused
      cutFrame_r <= mdioOe && (cutFrame_r || reset || softRst);
      if (reset) begin
         cfgShadow_r <= `CFG_RST;
      end else if (regWrite && regAddr == `REG_MODE_CFG) begin
         cfgShadow_r <= regWrData;
      end
   end
   default clocking dc @(posedge mclk); endclocking
   default disable iff (reset);
   property p_strap_latch;
      $fell(reset) |-> ##2 modeStatus.miiSel == $past(linkIndIn, 2)
         && modeStatus.attach == {1'b0, $past(phySocStrap, 2)}
         && !modeStatus.clkInt;
   endproperty
   a_strap_latch: assert property (p_strap_latch)
      else $error("strap mode wrong");
   property p_cfg_hold;
      regWrite && regAddr == `REG_MODE_CFG |=> $stable(modeStatus);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold)
      else $error("mode changed without soft reset");
   property p_soft_apply;
      softRst && cfgShadow_r[`CFG_OVERRIDE] |=> modeStatus ==
         {cfgShadow_r[5], cfgShadow_r[4:3], ~cfgShadow_r[6]};
   endproperty
   a_soft_apply: assert property (p_soft_apply)
      else $error("soft reset mode wrong");
   property p_clk_ext;
      settled && $stable(modeStatus) && !modeStatus.clkInt
         |-> !refClkOe && !refClkOut;
   endproperty
   a_clk_ext: assert property (p_clk_ext)
      else $error("ref driven with external source");
   property p_ref_oe;
      settled && $stable(modeStatus) && refClkOe
         |-> modeStatus.clkInt && !modeStatus.miiSel;
   endproperty
   a_ref_oe: assert property (p_ref_oe)
      else $error("ref enable outside rmii internal");
   property p_ref_shape;
      $rose(refClkOut) |-> ##1 (refClkOut || !refClkOe)
         ##1 !refClkOut[*3] ##1 (refClkOut || !refClkOe);
   endproperty
   a_ref_shape: assert property (p_ref_shape)
      else $error("ref clock shape wrong");
   property p_soc_quiet;
      settled && $stable(modeStatus) && modeStatus.attach != `ATTACH_PHY
         |-> !mdcOe && !mdioOe && !mdc;
   endproperty
   a_soc_quiet: assert property (p_soc_quiet)
      else $error("management active outside phy mode");
   property p_media_map;
      settled && $stable(modeStatus) |-> media.rmii == !modeStatus.miiSel
         && media.mediaClkOe == (modeStatus.attach == `ATTACH_SOC)
         && media.mdcOe == (modeStatus.attach == `ATTACH_PHY);
   endproperty
   a_media_map: assert property (p_media_map)
      else $error("media controls wrong");
   property p_portb;
      settled && $stable(modeStatus) && modeStatus.miiSel
         && modeStatus.attach == `ATTACH_SOC |-> media.portBEn
         && !media.portAEn;
   endproperty
   a_portb: assert property (p_portb)
      else $error("soc mii not on port b");
   property p_frame_hdr;
      $rose(mdioOe) |-> mdioOut && !mdc;
   endproperty
   a_frame_hdr: assert property (p_frame_hdr)
      else $error("read frame does not open with idle mdc");
   property p_frame_len;
      $fell(mdioOe) && !cutFrame_r |-> oeLen_r == 16'(HDR_LEN);
   endproperty
   a_frame_len: assert property (p_frame_len)
      else $error("read frame header length wrong");
endmodule : msmp_top_asserts

bind msmp_top msmp_top_asserts #(.MDC_HALF(MDC_HALF)) uChk (
   .mclk(mclk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
   .regWrite(regWrite), .linkIndIn(linkIndIn), .phySocStrap(phySocStrap),
   .refClkOut(refClkOut), .refClkOe(refClkOe), .mdc(mdc), .mdcOe(mdcOe),
   .mdioOut(mdioOut), .mdioOe(mdioOe), .media(media),
   .modeStatus(modeStatus));

// ==== testbench/msmp_phy_model.sv ====
// Purpose: management target of an external phy
// Assumes: frame starts when the host enables mdio
// Notes: releases mdio outside the data bits
`timescale 1ns/1ns
module msmp_phy_model (
   input wire logic mdc,
   input wire logic mdioOe,
   input wire logic mdio,
   input wire logic [4:0] myAddr,
   input wire logic linkUp,
   output logic drvOut,
   output logic drvOe
);
   int cnt = 99;
   logic [9:0] sh = '0;
   logic [15:0] dat = '0;
   logic hit = 1'b0;
   initial begin
      drvOut = 1'b0;
      drvOe = 1'b0;
   end
   always @(posedge mdioOe) cnt = 0;
   always @(posedge mdc) begin
      sh = {sh[8:0], mdio};
      cnt = cnt + 1;
   end
   always @(negedge mdc) begin
      if (cnt == 46) begin
         hit = sh == {myAddr, 5'h01};
         dat = linkUp ? 16'h8004 : 16'h7ffb;
      end
      drvOe = hit && cnt >= 48 && cnt <= 63;
      if (drvOe) begin
         drvOut = dat[63 - cnt];
      end
   end
endmodule : msmp_phy_model

// ==== testbench/msmp_top_tb.sv ====
// Purpose: self-checking bench for msmp_top
// Assumes: short poll and mdc counts
// Notes: phy model answers reads at address 16h
`timescale 1ns/1ns
`include "msmp_map.svh"
module msmp_top_tb;
   import msmp_pkg::*;
   logic mclk, reset, regWrite, regRead, strapMii, phySocStrap;
   logic extClk, extRun, phyLink, phyOut, phyOe, linkIndOut, linkIndOe;
   logic refClkOut, refClkOe, mdc, mdcOe, mdioOut, mdioOe;
   logic [7:0] regAddr, regWrData, regRdData, rd, keep;
   logic [1:0] addrSel;
   msmp_media_t media;
   msmp_mode_t modeStatus;
   int fails, checkCount;
   // cfg value beside expected {miiSel, attach, clkInt}
   logic [11:0] rows [8] = '{12'h618, 12'h69a, 12'h71c, 12'h011,
      12'h093, 12'h115, 12'h410, 12'h492};
   wire linkIndIn = linkIndOe ? linkIndOut : strapMii;
   wire mdioIn = mdioOe ? mdioOut : (phyOe ? phyOut : 1'b1);
   wire refClkIn = refClkOe ? refClkOut : extClk;
   msmp_top #(.POLL_CYCLES(200), .MDC_HALF(4)) DUT (
      .mclk(mclk), .reset(reset), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .linkIndIn(linkIndIn),
      .linkIndOut(linkIndOut), .linkIndOe(linkIndOe),
      .phySocStrap(phySocStrap), .addrSel(addrSel), .refClkIn(refClkIn),
      .refClkOut(refClkOut), .refClkOe(refClkOe), .mdc(mdc),
      .mdcOe(mdcOe), .mdioIn(mdioIn), .mdioOut(mdioOut),
      .mdioOe(mdioOe), .media(media), .modeStatus(modeStatus));
   msmp_phy_model uPhy (.mdc(mdc), .mdioOe(mdioOe), .mdio(mdioIn),
      .myAddr(5'h16), .linkUp(phyLink), .drvOut(phyOut), .drvOe(phyOe));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      extClk = 1'b0;
      forever begin
         #62 extClk = extRun & ~extClk;
         #63 extClk = extRun & ~extClk;
      end
   end
   task automatic completeRun;
      $display("checks %0d mismatches %0d", checkCount, fails);
      if (fails == 0 && checkCount > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : completeRun
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checkCount++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
   endtask : wr
   task automatic rdReg(input logic [7:0] a);
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      #1 rd = regRdData;
   endtask : rdReg
   task automatic hwReset(input logic mii, input logic soc);
      @(posedge mclk);
      reset <= 1'b1;
      strapMii <= mii;
      phySocStrap <= soc;
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      repeat (3) @(posedge mclk);
      #1;
   endtask : hwReset
   // second round sees a frame started after the change
   task automatic pollStat;
      int n;
      repeat (2) begin
         wr(`REG_SOFT_RESET, 8'h01);
         n = 0;
         rd = 8'h00;
         while (rd[5] !== 1'b1 && n < 1000) begin
            rdReg(`REG_STATUS);
            n++;
         end
         if (rd[5] !== 1'b1) begin
            chk(rd[5], 1'b1);
            completeRun();
         end
      end
   endtask : pollStat
   initial begin
      reset = 1'b1;
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 8'h00;
      regWrData = 8'h00;
      addrSel = 2'b10;
      strapMii = 1'b1;
      phySocStrap = 1'b1;
      extRun = 1'b0;
      phyLink = 1'b1;
      fails = 0;
      checkCount = 0;
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      repeat (3) @(posedge mclk);
      #1 chk(modeStatus, 4'ha);
      chk(media.mediaClkOe, 1'b1);
      chk(linkIndOe, 1'b1);
      foreach (rows[i]) begin
         wr(`REG_MODE_CFG, rows[i][11:4]);
         rdReg(`REG_MODE_CFG);
         chk(rd, rows[i][11:4]);
         wr(`REG_SOFT_RESET, 8'h01);
         repeat (2) @(posedge mclk);
         #1 chk(modeStatus, rows[i][3:0]);
         chk(refClkOe, rows[i][0] & ~rows[i][3]);
         chk(mdcOe, rows[i][2:1] == 2'b00);
         rdReg(`REG_STATUS);
         chk(rd[3:0], {rows[i][0], rows[i][2:1], rows[i][3]});
      end
      hwReset(1'b0, 1'b0);
      chk(modeStatus, 4'h0);
      rdReg(`REG_MODE_CFG);
      chk(rd, `CFG_RST);
      rdReg(`REG_PHY_ADDR_HI);
      chk(rd, `PHYHI_RST);
      rdReg(8'h33);
      chk(rd, 8'h00);
      repeat (100) @(posedge mclk);
      rdReg(`REG_STATUS);
      chk(rd[6], 1'b0);
      extRun <= 1'b1;
      wr(`REG_PHY_ADDR_HI, 8'h50);
      pollStat();
      chk(rd[6:4], 3'b111);
      chk(linkIndOut, 1'b0);
      chk(modeStatus, 4'h0);
      phyLink <= 1'b0;
      pollStat();
      chk(rd[4], 1'b0);
      chk(linkIndOut, 1'b1);
      @(posedge mclk);
      addrSel <= 2'b01;
      pollStat();
      chk(rd[4], 1'b1);
      keep = rd;
      wr(`REG_STATUS, 8'hff);
      rdReg(`REG_STATUS);
      chk(rd, keep);
      completeRun();
   end
endmodule : msmp_top_tb
